// *** design/hbd_core.sv ***
`timescale 1ns/1ps
`include "hbd_cfg.svh"
// Function
// (RQ1) master sends 24-bit frame: 8-bit device word first, then ours
// (RQ2) status words return in same order, shifted out with commands
// (RQ3) all chained devices share this clock phase and polarity
// (RQ4) master avoids misordered frames of legal length
// (RQ5) misordered but legal-length frames are accepted as a command
// (RQ6) serial out carries thermal latch ORed with serial in before data
// (RQ7) master idles select high, clock and data low before a frame
// (RQ8) select fall shows thermal bit; status follows first rising edge
// (RQ9) master reads every status word to locate a thermal fault
// (RQ10) power-on reset zeroes command and status, outputs high impedance
// (RQ11) traffic and operation only after reset and while enable high
// (RQ12) supply lockout turns drivers off, keeps command and status
// (RQ13) overvoltage leaves outputs on when overvoltage lockout disabled
// (RQ14) output state follows command and current fault status
// (RQ15) group select bit picks which six channels a frame addresses
// (RQ16) high and low side never on together; dead time between them
// (RQ17) enabled drivers stay on until commanded off or faulted
// (RQ18) thermal, overcurrent, underload faults latch; cleared by reset
// (RQ19) supply faults auto recover, non-latched; config writable meanwhile
// (RQ20) after supply recovery outputs take current written configuration
// (RQ21) supply fail and thermal warning flags clear by themselves
// (RQ22) warning and bridge status report; protection faults act
// (RQ23) last 16 bits load only on a frame without length error
// (RQ24) status reset clears latches, restarts outputs of selected group
// (RQ25) underload does not switch off when its shutdown enable is 0

module hbd_core
   import hbd_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        spi_sclk,
   input  wire logic        chip_select_n,
   input  wire logic        spi_si,
   output logic             spi_so,
   output logic             spi_so_oe,
   input  wire logic        enable_pin,
   input  wire hbd_fault_t  fault_in,
   output logic [11:0]      high_side_switch,
   output logic [11:0]      low_side_switch,
   output logic [15:0]      command_word,
   output logic [15:0]      status_word
);

   // ****************************************************************
   // link domain: shift path on the serial clock
   // ****************************************************************
   logic [16:0] shift_reg;
   logic [4:0]  bit_cnt_reg;
   logic [4:0]  bit_cnt_next;
   logic        started_reg;
   logic        frame_ok_reg;
   logic        frame_tog_reg;

   // frame-length counter: modulo 16 for the first word, modulo 8 after
   always_comb begin
      if (!started_reg) begin
         bit_cnt_next = `HBD_CNT_START;
      end else if (bit_cnt_reg == `HBD_CNT_WRAP) begin
         bit_cnt_next = `HBD_CNT_FIRST;
      end else begin
         bit_cnt_next = bit_cnt_reg + 5'h01;
      end
   end

   // select high clears the first-edge marker; a clock that stops
   // outside frames gives no other chance to do it
   always_ff @(posedge spi_sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         started_reg <= 1'b0;
      end else begin
         started_reg <= 1'b1;                       // [RQ8]
      end
   end

   // one shift path: status loads on the first edge, serial in follows
   // so that upstream words pass straight through the chain
   always_ff @(posedge spi_sclk) begin
      if (!started_reg) begin
         shift_reg <= {status_word, spi_si};        // [RQ2]
      end else begin
         shift_reg <= {shift_reg[15:0], spi_si};    // [RQ2] [RQ5]
      end
   end

   // length bookkeeping for the frame-error check
   always_ff @(posedge spi_sclk) begin
      bit_cnt_reg  <= bit_cnt_next;
      frame_ok_reg <= (bit_cnt_next == `HBD_CNT_FIRST); // [RQ23]
   end

   // toggle that marks a clocked frame; it needs a known start level
   // or the system side never sees a change; the link clock stands
   // still while reset is applied, so the release is safe
   always_ff @(posedge spi_sclk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_tog_reg <= 1'b0;
      end else if (!started_reg) begin
         frame_tog_reg <= ~frame_tog_reg;
      end
   end

   // ****************************************************************
   // serial output path
   // ****************************************************************
   logic tsd_any;

   // before the first edge the thermal latch, ORed with serial in,
   // ripples down the chain; afterwards the shift path drives
   always_comb begin
      if (!started_reg) begin
         spi_so = tsd_any | spi_si;                 // [RQ6] [RQ8]
      end else begin
         spi_so = shift_reg[16];                    // [RQ6]
      end
   end

   // ****************************************************************
   // system domain: synchronisers
   // ****************************************************************
   logic [2:0]  cs_sync_reg;
   logic [2:0]  tog_sync_reg;
   logic [1:0]  en_sync_reg;
   hbd_fault_t  flt_meta_reg;
   hbd_fault_t  flt_reg;

   // select and toggle get a third stage purely for edge detection
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_sync_reg  <= 3'h7;
         tog_sync_reg <= 3'h0;
         en_sync_reg  <= 2'h0;
      end else if (clk_en) begin
         cs_sync_reg  <= {cs_sync_reg[1:0], chip_select_n};
         tog_sync_reg <= {tog_sync_reg[1:0], frame_tog_reg};
         en_sync_reg  <= {en_sync_reg[0], enable_pin};
      end
   end

   // analog detector levels are asynchronous to this clock
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flt_meta_reg <= '0;
         flt_reg      <= '0;
      end else if (clk_en) begin
         flt_meta_reg <= fault_in;
         flt_reg      <= flt_meta_reg;
      end
   end

   logic running;
   logic cs_rise;
   logic clocked;
   assign running = en_sync_reg[1];                 // [RQ11]
   assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
   assign clocked = tog_sync_reg[1] ^ tog_sync_reg[2];

   // the link output is driven only inside a frame while enabled
   assign spi_so_oe = running & ~chip_select_n;     // [RQ10] [RQ11]

   // ****************************************************************
   // frame acceptance: link flops are quiet once select is high
   // ****************************************************************
   logic     seen_edge_reg;
   logic     load_cmd;
   hbd_cmd_t new_cmd;

   // remembers that at least one clock edge came in this frame
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seen_edge_reg <= 1'b0;
      end else if (clk_en) begin
         if (cs_rise) begin
            seen_edge_reg <= 1'b0;
         end else if (clocked) begin
            seen_edge_reg <= 1'b1;
         end
      end
   end

   assign new_cmd  = hbd_cmd_t'(shift_reg[15:0]);   // [RQ23]
   assign load_cmd = cs_rise & running & (seen_edge_reg | clocked)
                     & frame_ok_reg;                // [RQ11] [RQ23]

   // ****************************************************************
   // command storage, one enable and side select per channel
   // ****************************************************************
   hbd_cmd_t    cmd_reg;
   logic [11:0] ch_en_reg;
   logic [11:0] ch_hs_reg;
   logic        grp_reg;
   logic        underload_shutdown_enable_reg;
   logic        overvoltage_lockout_enable_reg;
   logic [11:0] grp_mask;
   logic [11:0] srr_clr;

   // a frame only rewrites the six channels of the group it names;
   // supply lockout does not touch this storage
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_reg   <= hbd_cmd_t'(`HBD_CMD_RST);     // [RQ10]
         ch_en_reg <= `HBD_CH_RST;
         ch_hs_reg <= `HBD_CH_RST;
         grp_reg   <= 1'b0;
         underload_shutdown_enable_reg <= 1'b0;
         overvoltage_lockout_enable_reg  <= 1'b0;
      end else if (clk_en) begin
         if (!running) begin
            cmd_reg   <= hbd_cmd_t'(`HBD_CMD_RST);
            ch_en_reg <= `HBD_CH_RST;
            ch_hs_reg <= `HBD_CH_RST;
            grp_reg   <= 1'b0;
            underload_shutdown_enable_reg <= 1'b0;
            overvoltage_lockout_enable_reg  <= 1'b0;
         end else if (load_cmd) begin               // [RQ12] [RQ19]
            cmd_reg   <= new_cmd;
            grp_reg   <= new_cmd.grp;               // [RQ15]
            underload_shutdown_enable_reg <= new_cmd.underload_shutdown_enable;
            overvoltage_lockout_enable_reg  <= new_cmd.overvoltage_lockout_enable;
            if (new_cmd.grp) begin
               ch_en_reg[11:6] <= new_cmd.enable;
               ch_hs_reg[11:6] <= new_cmd.high_sel;
            end else begin
               ch_en_reg[5:0] <= new_cmd.enable;
               ch_hs_reg[5:0] <= new_cmd.high_sel;
            end
         end
      end
   end

   assign command_word = cmd_reg;
   assign grp_mask = new_cmd.grp ? 12'hFC0 : 12'h03F;
   assign srr_clr  = (load_cmd & new_cmd.status_reset_request) ? grp_mask : 12'h000;

   // ****************************************************************
   // latched protection faults
   // ****************************************************************
   logic [11:0] tsd_lat_reg;
   logic [11:0] ocs_lat_reg;
   logic [11:0] uld_lat_reg;

   // a detector still active in the clearing cycle keeps its latch set
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tsd_lat_reg <= `HBD_CH_RST;                // [RQ10]
         ocs_lat_reg <= `HBD_CH_RST;
         uld_lat_reg <= `HBD_CH_RST;
      end else if (clk_en) begin
         if (!running) begin
            tsd_lat_reg <= `HBD_CH_RST;
            ocs_lat_reg <= `HBD_CH_RST;
            uld_lat_reg <= `HBD_CH_RST;
         end else begin
            tsd_lat_reg <= flt_reg.thermal_shutdown
                           | (tsd_lat_reg & ~srr_clr);   // [RQ18] [RQ24]
            ocs_lat_reg <= flt_reg.overcurrent
                           | (ocs_lat_reg & ~srr_clr);   // [RQ18] [RQ24]
            uld_lat_reg <= flt_reg.underload
                           | (uld_lat_reg & ~srr_clr);   // [RQ18] [RQ24]
         end
      end
   end

   assign tsd_any = |tsd_lat_reg;

   // ****************************************************************
   // output decision and non-overlap sequencing per channel
   // ****************************************************************
   logic        lockout;
   logic [11:0] drive_ok;

   // undervoltage always locks out; overvoltage only when enabled
   assign lockout = flt_reg.supply_under
                    | (flt_reg.supply_over & overvoltage_lockout_enable_reg);  // [RQ12] [RQ13]

   // warning never enters here; underload only with its shutdown enable
   assign drive_ok = {12{running & ~lockout}} & ch_en_reg
                     & ~tsd_lat_reg & ~ocs_lat_reg
                     & ~(uld_lat_reg & {12{underload_shutdown_enable_reg}}); // [RQ14] [RQ22] [RQ25]

   genvar ch;
   generate
      for (ch = 0; ch < `HBD_CHANNELS; ch = ch + 1) begin : g_ch
         hbd_sw_t   sw_reg;
         hbd_sw_t   want;
         logic [7:0] dead_reg;

         // live command re-read each cycle, so recovery takes the
         // newest configuration
         always_comb begin
            if (!drive_ok[ch]) begin
               want = HBD_SW_OFF;                   // [RQ14] [RQ20]
            end else if (ch_hs_reg[ch]) begin
               want = HBD_SW_HIGH;
            end else begin
               want = HBD_SW_LOW;
            end
         end

         // any change passes through off plus dead time before the
         // opposite switch may close
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               sw_reg   <= HBD_SW_OFF;              // [RQ10]
               dead_reg <= `HBD_DEAD_RST;
            end else if (clk_en) begin
               case (sw_reg)
                  HBD_SW_OFF: begin
                     if (dead_reg != `HBD_DEAD_RST) begin
                        dead_reg <= dead_reg - 8'h01;   // [RQ16]
                     end else begin
                        sw_reg <= want;
                     end
                  end
                  default: begin
                     if (want != sw_reg) begin
                        sw_reg   <= HBD_SW_OFF;      // [RQ16] [RQ17]
                        dead_reg <= 8'(`HBD_DEAD_CYC);
                     end
                  end
               endcase
            end
         end

         assign high_side_switch[ch] = (sw_reg == HBD_SW_HIGH);
         assign low_side_switch[ch]  = (sw_reg == HBD_SW_LOW);
      end
   endgenerate

   // ****************************************************************
   // status word
   // ****************************************************************
   function automatic logic [1:0] hbd_hbst(input logic ocs,
                                            input logic underload_flag,
                                            input logic on);
      if (ocs) begin
         hbd_hbst = `HBD_HBST_OCS;
      end else if (underload_flag) begin
         hbd_hbst = `HBD_HBST_ULD;
      end else if (on) begin
         hbd_hbst = `HBD_HBST_ON;
      end else begin
         hbd_hbst = `HBD_HBST_OFF;
      end
   endfunction : hbd_hbst

   logic [5:0]  g_ocs;
   logic [5:0]  g_uld;
   logic [5:0]  g_on;
   logic [15:0] status_next;
   integer      k;

   assign g_ocs = grp_reg ? ocs_lat_reg[11:6] : ocs_lat_reg[5:0];
   assign g_uld = grp_reg ? uld_lat_reg[11:6] : uld_lat_reg[5:0];
   assign g_on  = grp_reg ? (high_side_switch[11:6] | low_side_switch[11:6])
                          : (high_side_switch[5:0] | low_side_switch[5:0]);

   // supply fail and warning follow the detectors with no memory
   always_comb begin
      status_next = `HBD_STA_RST;
      status_next[`HBD_STA_OCS] = |g_ocs;
      status_next[`HBD_STA_PSF] = flt_reg.supply_under
                                  | flt_reg.supply_over;    // [RQ19] [RQ21]
      status_next[`HBD_STA_ULD] = |g_uld;
      status_next[`HBD_STA_TW]  = |flt_reg.thermal_warning; // [RQ21] [RQ22]
      for (k = 0; k < `HBD_GROUP_CH; k = k + 1) begin
         status_next[2*k+1 +: 2] = hbd_hbst(g_ocs[k], g_uld[k], g_on[k]);
      end
   end

   logic [15:0] status_reg;

   // frozen while select is low: the link domain reads it on its
   // first edge, so it must hold still for the whole frame
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         status_reg <= `HBD_STA_RST;                // [RQ10]
      end else if (clk_en) begin
         if (!running) begin
            status_reg <= `HBD_STA_RST;
         end else if (cs_sync_reg[1] & ~cs_rise) begin
            status_reg <= status_next;
         end
      end
   end

   assign status_word = status_reg;

endmodule : hbd_core

// *** design/hbd_cfg.svh ***
`ifndef HBD_CFG_SVH
`define HBD_CFG_SVH

// ****************************************************************
// frame geometry
// ****************************************************************
`define HBD_WORD_BITS      16
`define HBD_CNT_FIRST      5'h10
`define HBD_CNT_WRAP       5'h17
`define HBD_CNT_START      5'h01
`define HBD_SHIFT_BITS     17

// ****************************************************************
// command word field positions
// ****************************************************************
`define HBD_CMD_SRR        15
`define HBD_CMD_GRP        14
`define HBD_CMD_EN_HI      13
`define HBD_CMD_EN_LO      8
`define HBD_CMD_CFG_HI     7
`define HBD_CMD_CFG_LO     2
`define HBD_CMD_UNDERLOAD_SHUTDOWN_ENABLE      1
`define HBD_CMD_OVERVOLTAGE_LOCKOUT_ENABLE       0

// ****************************************************************
// status word field positions and half-bridge codes
// ****************************************************************
`define HBD_STA_OCS        15
`define HBD_STA_PSF        14
`define HBD_STA_ULD        13
`define HBD_STA_TW         0
`define HBD_HBST_OFF       2'h0
`define HBD_HBST_OCS       2'h1
`define HBD_HBST_ULD       2'h2
`define HBD_HBST_ON        2'h3

// ****************************************************************
// reset values and channel counts
// ****************************************************************
`define HBD_CMD_RST        16'h0000
`define HBD_STA_RST        16'h0000
`define HBD_CH_RST         12'h000
`define HBD_CHANNELS       12
`define HBD_GROUP_CH       6

// ****************************************************************
// timing
// ****************************************************************
`define HBD_CLK_NS         8
`define HBD_DEAD_NS        1000
`define HBD_DEAD_CYC       ((`HBD_DEAD_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS)
`define HBD_DEAD_RST       8'h00

`endif

// *** design/hbd_pkg.sv ***
package hbd_pkg;

   // command word as shifted in, msb first
   typedef struct packed {
      logic       status_reset_request;
      logic       grp;
      logic [5:0] enable;
      logic [5:0] high_sel;
      logic       underload_shutdown_enable;
      logic       overvoltage_lockout_enable;
   } hbd_cmd_t;

   // qualified detector levels from the analog side
   typedef struct packed {
      logic [11:0] thermal_shutdown;
      logic [11:0] overcurrent;
      logic [11:0] underload;
      logic [11:0] thermal_warning;
      logic        supply_under;
      logic        supply_over;
   } hbd_fault_t;

   // per channel switch phase
   typedef enum logic [1:0] {
      HBD_SW_OFF  = 2'b00,
      HBD_SW_HIGH = 2'b01,
      HBD_SW_LOW  = 2'b10
   } hbd_sw_t;

endpackage : hbd_pkg

// *** testbench/hbd_chk.sv ***
`timescale 1ns/1ps
module hbd_chk
   import hbd_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        chip_select_n,
   input wire logic        spi_so_oe,
   input wire logic        enable_pin,
   input wire hbd_fault_t  fault_in,
   input wire logic [11:0] high_side_switch,
   input wire logic [11:0] low_side_switch,
   input wire logic [15:0] command_word,
   input wire logic [15:0] status_word
);
   // ***************************************************
   // helper state
   // ***************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] off_cnt_reg;

   // cycles channel 1 has spent with both switches open
   always_ff @(posedge ref_clk) begin
      if (sys_rst || high_side_switch[1] || low_side_switch[1])
         off_cnt_reg <= 8'h00;
      else if (off_cnt_reg != 8'hFF)
         off_cnt_reg <= off_cnt_reg + 8'h01;
   end

   // frame in progress with the part enabled, long enough to be synced
   sequence frame_settled;
      (!chip_select_n && enable_pin) [*5];
   endsequence
   // supply low long enough to pass the input synchronisers
   sequence lockout_held;
      fault_in.supply_under [*5];
   endsequence

   // ***************************************************
   // assertions
   // ***************************************************
   no_shoot_a:
      assert property ((high_side_switch & low_side_switch) == 12'h000)
      else $error("high and low side closed together");
   dead_time_a:
      assert property ($rose(low_side_switch[1]) |-> off_cnt_reg >= 8'h7D)
      else $error("low side closed before the dead time ran out");
   reset_clear_a:
      assert property (disable iff (1'b0) sys_rst |=> command_word == 16'h0000
         && status_word == 16'h0000 && !spi_so_oe
         && (high_side_switch | low_side_switch) == 12'h000)
      else $error("reset left state or drivers active");
   oe_select_a:
      assert property (spi_so_oe |-> !chip_select_n)
      else $error("serial out driven while not selected");
   oe_enable_a:
      assert property (enable_pin [*4] ##0 !chip_select_n |-> spi_so_oe)
      else $error("serial out not driven in a frame");
   status_frozen_a:
      assert property (frame_settled ##1 !chip_select_n |-> $stable(status_word))
      else $error("status changed during a frame");
   cmd_hold_a:
      assert property (frame_settled |-> $stable(command_word))
      else $error("command changed during a frame");
   lockout_off_a:
      assert property (lockout_held |->
         (high_side_switch | low_side_switch) == 12'h000)
      else $error("drivers on during supply lockout");
   tsd_off_a:
      assert property (fault_in.thermal_shutdown[0] [*5] |->
         !high_side_switch[0] && !low_side_switch[0])
      else $error("channel 0 on during thermal shutdown");
endmodule : hbd_chk

bind hbd_core hbd_chk u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
   .spi_so_oe(spi_so_oe), .enable_pin(enable_pin), .fault_in(fault_in),
   .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
   .command_word(command_word), .status_word(status_word));

// *** testbench/hbd_spi_master.sv ***
`timescale 1ns/1ps
module hbd_spi_master
(
   output logic      spi_sclk,
   output logic      chip_select_n,
   output logic      spi_si,
   input  wire logic spi_so,
   input  wire logic spi_so_oe
);
   // ***************************************************
   // serial master
   // ***************************************************
   localparam int HALF_NS = 24;

   // idle: select high, clock and data low between frames
   initial begin
      spi_sclk      = 1'b0;
      chip_select_n = 1'b1;
      spi_si        = 1'b0;
   end

   // msb first, data set after the falling edge, sampled on the rise;
   // clock stands still outside frames, undriven reply reads as x
   task automatic xfer(input int nbits, input logic [23:0] tx,
                       output logic [23:0] rx, output logic [1:0] pre);
      #7;
      chip_select_n = 1'b0;
      #20;
      pre[1] = spi_so_oe ? spi_so : 1'bx;
      spi_si = tx[nbits-1];
      #20;
      pre[0] = spi_so_oe ? spi_so : 1'bx;
      rx = 24'h00_0000;
      for (int i = 0; i < nbits; i++) begin
         spi_si = tx[nbits-1-i];
         #HALF_NS spi_sclk = 1'b1;
         #HALF_NS spi_sclk = 1'b0;
         rx = {rx[22:0], spi_so_oe ? spi_so : 1'bx};
      end
      spi_si = 1'b0;
      #HALF_NS chip_select_n = 1'b1;
      #80;
   endtask : xfer
endmodule : hbd_spi_master

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import hbd_pkg::*;
   logic        ref_clk;
   logic        sys_rst;
   logic        enable_pin;
   hbd_fault_t  flt;
   logic        spi_sclk;
   logic        chip_select_n;
   logic        spi_si;
   logic        spi_so;
   logic        so_oe;
   logic [11:0] hs;
   logic [11:0] ls;
   logic [15:0] cmd_w;
   logic [15:0] sta_w;
   logic [23:0] rx;
   logic [1:0]  pre;
   int          err_total;
   int          samples_checked;

   // ***************************************************
   // clock, design and master
   // ***************************************************
   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   hbd_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .spi_sclk(spi_sclk), .chip_select_n(chip_select_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe(so_oe), .enable_pin(enable_pin),
      .fault_in(flt), .high_side_switch(hs), .low_side_switch(ls),
      .command_word(cmd_w), .status_word(sta_w));
   hbd_spi_master master (.spi_sclk(spi_sclk),
      .chip_select_n(chip_select_n), .spi_si(spi_si), .spi_so(spi_so),
      .spi_so_oe(so_oe));

   // ***************************************************
   // tasks
   // ***************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   task automatic chk(input string what, input logic [23:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic sw(input logic [11:0] h, l);
      chk("high side", {12'h000, h}, {12'h000, hs});
      chk("low side", {12'h000, l}, {12'h000, ls});
   endtask : sw

   // frame, then enough cycles for the command to land
   task automatic frame(input int n, input logic [23:0] tx);
      master.xfer(n, tx, rx, pre);
      tick(12);
   endtask : frame

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // watchdog well past the roughly 2800 cycles the tests need
   initial begin
      tick(60000);
      err_total++;
      conclude();
   end

   // ***************************************************
   // tests
   // ***************************************************
   initial begin
      sys_rst         = 1'b1;
      enable_pin      = 1'b1;
      flt             = '0;
      err_total       = 0;
      samples_checked = 0;
      tick(2);
      sys_rst <= 1'b0;
      tick(1);
      chk("command", 16'h0000, cmd_w);
      chk("status", 16'h0000, sta_w);
      chk("so enable", 1'b0, so_oe);
      sw(12'h000, 12'h000);
      tick(8);
      $display("test reset done");
      frame(16, 24'h00_3FAB);
      chk("command", 16'h3FAB, cmd_w);
      tick(140);
      sw(12'h02A, 12'h015);
      frame(16, 24'h00_3FAB);
      chk("status", 16'h1FFE, rx[15:0]);
      chk("pre bit", 2'b00, pre);
      $display("test write done");
      frame(24, 24'hA5_4100);
      chk("chain status", 16'h1FFE, rx[23:8]);
      chk("chain echo", 8'hA5, rx[7:0]);
      chk("command", 16'h4100, cmd_w);
      tick(140);
      sw(12'h02A, 12'h055);
      frame(12, 24'h00_0FFF);
      chk("command", 16'h4100, cmd_w);
      frame(24, 24'h41_0302);
      chk("command", 16'h0302, cmd_w);
      tick(140);
      sw(12'h000, 12'h043);
      $display("test chain done");
      flt.supply_over <= 1'b1;
      tick(10);
      sw(12'h000, 12'h043);
      frame(16, 24'h00_0302);
      chk("supply fail", 1'b1, rx[14]);
      flt.supply_over  <= 1'b0;
      flt.supply_under <= 1'b1;
      tick(10);
      sw(12'h000, 12'h000);
      frame(16, 24'h00_3FFD);
      chk("command", 16'h3FFD, cmd_w);
      sw(12'h000, 12'h000);
      flt.supply_under <= 1'b0;
      tick(140);
      sw(12'h03F, 12'h040);
      $display("test supply done");
      flt.thermal_warning[2] <= 1'b1;
      tick(6);
      frame(16, 24'h00_3FFD);
      chk("status", 16'h1FFF, rx[15:0]);
      sw(12'h03F, 12'h040);
      flt.thermal_warning[2] <= 1'b0;
      tick(6);
      frame(16, 24'h00_3FFD);
      chk("status", 16'h1FFE, rx[15:0]);
      $display("test warning done");
      flt.thermal_shutdown[0] <= 1'b1;
      tick(10);
      flt.thermal_shutdown[0] <= 1'b0;
      tick(6);
      frame(16, 24'h00_3FFD);
      chk("pre bit", 2'b11, pre);
      sw(12'h03E, 12'h040);
      frame(16, 24'h00_BFFD);
      tick(140);
      sw(12'h03F, 12'h040);
      $display("test shutdown done");
      flt.underload[0] <= 1'b1;
      tick(10);
      sw(12'h03F, 12'h040);
      frame(16, 24'h00_3FFD);
      chk("underload", 1'b1, rx[13]);
      chk("pre bit", 2'b00, pre);
      frame(16, 24'h00_3FFF);
      sw(12'h03E, 12'h040);
      flt.underload[0] <= 1'b0;
      frame(16, 24'h00_BFFF);
      chk("pre bit", 2'b01, pre);
      tick(140);
      sw(12'h03F, 12'h040);
      $display("test underload done");
      enable_pin <= 1'b0;
      tick(6);
      chk("command", 16'h0000, cmd_w);
      sw(12'h000, 12'h000);
      enable_pin <= 1'b1;
      tick(6);
      $display("test enable done");
      conclude();
   end
endmodule : testbench
